// ===== common/mpt_pkg.sv
// Constants for the eight-channel PWM timer: register map and field layout.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package mpt_pkg;
  localparam int NUM_CH     = 8;
  localparam int ADDR_W     = 8;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CLKSEL = 8'h04;
  localparam logic [7:0] OFS_PRESC  = 8'h08;
  localparam logic [7:0] OFS_OUT    = 8'h0C;
  localparam logic [7:0] OFS_PER    = 8'h20;
  localparam logic [7:0] OFS_DUTY   = 8'h40;
  localparam logic [7:0] OFS_CNT    = 8'h60;
  localparam logic [7:0] ARR_MASK   = 8'hE0;
  // Control register field positions.
  localparam int CTRL_EN    = 0;
  localparam int CTRL_POL   = 8;
  localparam int CTRL_CTR   = 16;
  localparam int CTRL_JOIN  = 24;
  // Prescaler register field positions.
  localparam int PRE_A      = 0;
  localparam int PRE_B      = 4;
  localparam int PRE_SA     = 8;
  localparam int PRE_SB     = 16;
  // Reset values.
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] PRESC_RST = 32'h0000_0000;
  localparam logic [7:0]  PER_RST   = 8'hFF;
  localparam logic [7:0]  DUTY_RST  = 8'h00;
  // AXI responses.
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // Scaled clock limit when the scale field is zero (divide by 512).
  localparam logic [8:0]  SCL_MAX   = 9'h1FF;
  // Clock source codes.
  typedef enum logic [1:0] {
    MPT_SRC_A  = 2'b00,
    MPT_SRC_B  = 2'b01,
    MPT_SRC_SA = 2'b10,
    MPT_SRC_SB = 2'b11
  } mpt_src_t;
endpackage

// ===== hdl/mpt_top.sv
// Eight-channel PWM timer with an AXI4-Lite register slave.
// Assumes one clock, aclk, and a synchronous active-low reset.
// Operation
// - Eight 8-bit channels, each with its own counter, period and duty.
// - An enabled channel runs on with no software action per period.
// - Duty spans 0 to 100 percent, constant levels included.
// - A per-channel polarity bit picks the level of the duty portion.
// - Each channel is left-aligned or centre-aligned on its own.
// - Only pairs 7/6, 5/4, 3/2 and 1/0 join, each as one 16-bit channel.
// - Pairs join independently, so every mix of widths is available.
// - Period and duty are double buffered, taken at zero or while off.
// - Each channel has its own enable and starts or stops alone.
// - Counters run from clock A, B or one of the two scaled clocks.
`timescale 1ns/10ps
module mpt_top #(
  parameter int NCH = mpt_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [mpt_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [mpt_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // PWM outputs
  output logic [NCH-1:0]                   pwm_out
);
  import mpt_pkg::*;

  if (NCH != NUM_CH) begin : g_chk
    $error("mpt_top supports exactly eight channels");
  end

  logic [31:0]         ctrl_r;
  logic [2*NCH-1:0]    clksel_r;
  logic [31:0]         presc_r;
  logic [7:0]          per_r  [NCH];
  logic [7:0]          duty_r [NCH];
  logic [15:0]         cnt_r  [NCH];
  logic [ADDR_W-1:0]   awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                aw_held_r;
  logic                w_held_r;
  logic                do_wr;
  logic [3:0]          ticks;
  logic [6:0]          pre_cnt_r;

  // Write channel: address and data are taken in either order.
  assign do_wr = aw_held_r & w_held_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_held_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map(awaddr_r) ? RESP_OK : RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  function automatic logic wr_map(input logic [ADDR_W-1:0] a);
    logic arr;
    arr = ((a & ARR_MASK) == OFS_PER) || ((a & ARR_MASK) == OFS_DUTY);
    return (a == OFS_CTRL) || (a == OFS_CLKSEL) || (a == OFS_PRESC) || arr;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Software-steered configuration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= CTRL_RST;
      clksel_r <= '0;
      presc_r  <= PRESC_RST;
    end else if (do_wr) begin
      if (awaddr_r == OFS_CTRL) ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
      if (awaddr_r == OFS_CLKSEL) begin
        clksel_r <= 16'(merge({16'h0000, clksel_r}, wdata_r, wstrb_r));
      end
      if (awaddr_r == OFS_PRESC) presc_r <= merge(presc_r, wdata_r, wstrb_r);
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= '0;
      unique case (s_axi_araddr & ARR_MASK)
        OFS_PER:  s_axi_rdata <= {24'h00_0000, per_r[s_axi_araddr[4:2]]};
        OFS_DUTY: s_axi_rdata <= {24'h00_0000, duty_r[s_axi_araddr[4:2]]};
        OFS_CNT:  s_axi_rdata <= {16'h0000, cnt_r[s_axi_araddr[4:2]]};
        default: begin
          if (s_axi_araddr == OFS_CTRL) s_axi_rdata <= ctrl_r;
          else if (s_axi_araddr == OFS_CLKSEL) begin
            s_axi_rdata <= {16'h0000, clksel_r};
          end else if (s_axi_araddr == OFS_PRESC) s_axi_rdata <= presc_r;
          else if (s_axi_araddr == OFS_OUT) begin
            s_axi_rdata <= {24'h00_0000, pwm_out};
          end else s_axi_rresp <= RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Base prescaler shared by clocks A and B.
  always_ff @(posedge aclk) begin
    if (!aresetn) pre_cnt_r <= '0;
    else pre_cnt_r <= pre_cnt_r + 7'h01;
  end

  for (genvar k = 0; k < 2; k++) begin : g_src
    logic [2:0] ex;
    logic [6:0] mask;
    logic [7:0] scl;
    logic [8:0] lim;
    logic [8:0] sc_cnt_r;
    assign ex   = presc_r[(k ? PRE_B : PRE_A) +: 3];
    assign mask = 7'((8'h01 << ex) - 8'h01);
    assign scl  = presc_r[(k ? PRE_SB : PRE_SA) +: 8];
    assign lim  = (scl == 8'h00) ? SCL_MAX : {scl, 1'b0} - 9'h001;
    // The scaled clock divides its base by twice the scale value.
    assign ticks[k]   = &(pre_cnt_r | ~mask);
    assign ticks[k+2] = ticks[k] & (sc_cnt_r >= lim);
    always_ff @(posedge aclk) begin
      if (!aresetn) sc_cnt_r <= '0;
      else if (ticks[k+2]) sc_cnt_r <= '0;
      else if (ticks[k]) sc_cnt_r <= sc_cnt_r + 9'h001;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic        joined;
    logic        slave;
    logic        run;
    logic        pol;
    logic        ctr;
    logic        tick;
    logic [15:0] per_b;
    logic [15:0] duty_b;
    logic [15:0] per_a_r;
    logic [15:0] duty_a_r;
    logic        dir_r;
    logic [15:0] cnt_nxt;
    logic        dir_nxt;
    logic        wrap;
    logic        act;

    assign joined = ctrl_r[CTRL_JOIN + i/2];
    // The low channel of a joined pair only lends its period and duty bytes.
    assign slave  = joined && (i % 2 == 0);
    assign run    = ctrl_r[CTRL_EN + i] & ~slave;
    assign pol    = ctrl_r[CTRL_POL + i];
    assign ctr    = ctrl_r[CTRL_CTR + i];
    assign tick   = ticks[clksel_r[2*i +: 2]];

    if (i % 2 == 1) begin : g_hi
      assign per_b  = joined ? {per_r[i], per_r[i-1]}
                             : {8'h00, per_r[i]};
      assign duty_b = joined ? {duty_r[i], duty_r[i-1]} : {8'h00, duty_r[i]};
    end else begin : g_lo
      assign per_b  = {8'h00, per_r[i]};
      assign duty_b = {8'h00, duty_r[i]};
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        per_r[i]  <= PER_RST;
        duty_r[i] <= DUTY_RST;
      end else if (do_wr && wstrb_r[0]) begin
        if (awaddr_r == OFS_PER + 8'(4*i)) per_r[i] <= wdata_r[7:0];
        if (awaddr_r == OFS_DUTY + 8'(4*i)) duty_r[i] <= wdata_r[7:0];
      end
    end

    always_comb begin
      dir_nxt = dir_r;
      if (per_a_r == 16'h0000) cnt_nxt = 16'h0000;
      else if (!ctr) begin
        cnt_nxt = (cnt_r[i] + 16'h0001 >= per_a_r) ? 16'h0000
                  : cnt_r[i] + 16'h0001;
      end else if (!dir_r && cnt_r[i] < per_a_r) begin
        cnt_nxt = cnt_r[i] + 16'h0001;
      end else begin
        cnt_nxt = cnt_r[i] - 16'h0001;
        dir_nxt = 1'b1;
      end
      wrap = (cnt_nxt == 16'h0000);
    end

    // Buffered values follow the registers while stopped and at each wrap.
    always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
        cnt_r[i] <= '0;
        dir_r    <= 1'b0;
        per_a_r  <= per_b;
        duty_a_r <= duty_b;
      end else if (tick) begin
        cnt_r[i] <= cnt_nxt;
        dir_r    <= wrap ? 1'b0 : dir_nxt;
        if (wrap) begin
          per_a_r  <= per_b;
          duty_a_r <= duty_b;
        end
      end
    end

    // Duty at or above the period holds the active level all period.
    assign act = (duty_a_r >= per_a_r) | (cnt_r[i] < duty_a_r);

    always_ff @(posedge aclk) begin
      if (!aresetn) pwm_out[i] <= 1'b1;
      else pwm_out[i] <= ~((act & run) ^ pol);
    end
  end
endmodule

// ===== testbench/mpt_assertions.sv
// Checker for the PWM timer bus handshake and reset levels.
// Assumes it is bound to mpt_top and sees only its ports.
`timescale 1ns/10ps
module mpt_chk #(parameter int NCH = 8) (
  // Clock and reset
  input logic           aclk,
  input logic           aresetn,
  // Register bus
  input logic           s_axi_awvalid,
  input logic           s_axi_awready,
  input logic           s_axi_wvalid,
  input logic           s_axi_wready,
  input logic [1:0]     s_axi_bresp,
  input logic           s_axi_bvalid,
  input logic           s_axi_bready,
  input logic           s_axi_arvalid,
  input logic           s_axi_arready,
  input logic [31:0]    s_axi_rdata,
  input logic [1:0]     s_axi_rresp,
  input logic           s_axi_rvalid,
  input logic           s_axi_rready,
  // Waveforms
  input logic [NCH-1:0] pwm_out
);
  import mpt_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_refused;
    (!s_axi_awready && !s_axi_wready) [*2];
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_wr_refused: assert property (s_wr_taken |=> s_wr_refused)
    else $error("write taken while busy");
  a_wr_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_wr_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not released");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rd_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_rd_release: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not released");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_ERR
    |-> s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
  a_reset_idle: assert property ($rose(aresetn) |->
    pwm_out == {NCH{1'b1}} && !s_axi_bvalid && !s_axi_rvalid)
    else $error("not idle after reset");
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the PWM timer: registers and waveforms.
// Assumes mpt_top with an AXI4-Lite slave and eight outputs.
`timescale 1ns/10ps
module tb;
  import mpt_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  pwm_out;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [7:0]  per[8], dty[8];
  int          failures = 0, comparisons = 0, cyc = 0;
  always #4 aclk = ~aclk;
  mpt_top dut (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pwm_out       (pwm_out)
  );
  task automatic check(input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // One compare per kind of result; all funnel into the same counters.
  task automatic check_wr(input logic [1:0] e, input logic [1:0] g);
    check(34'(e), 34'(g));
  endtask
  task automatic check_rd(input logic [33:0] e, input logic [33:0] g);
    check(e, g);
  endtask
  // Logic arguments, so an unknown level on a pin cannot slip through.
  task automatic check_pwm(input logic [15:0] e, input logic [15:0] g);
    check(34'(e), 34'(g));
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Ready lines stay high, so each task only waits for the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic pa, pw;
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do begin
      @(posedge aclk);
      pa = pa & ~s_axi_awready;
      pw = pw & ~s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end while (pa | pw);
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    rq.push_back({e, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask
  // Windows span whole periods, so the start phase does not matter.
  task automatic measure(input int ch, input int w, input int e);
    logic [15:0] n;
    n = 16'h0000;
    repeat (w) begin
      @(posedge aclk);
      n = n + pwm_out[ch];
    end
    check_pwm(16'(e), n);
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      check_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      check_wr(bq.pop_front(), s_axi_bresp);
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      results();
    end
  end
  initial begin
    int p, d, m, dv;
    logic [31:0] ctl, sel;
    void'($urandom(32'h533f_fbcb));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_pwm(16'h00FF, 16'(pwm_out));
    rd(OFS_CTRL, 32'h0000_0000, RESP_OK);
    rd(OFS_OUT, 32'h0000_00FF, RESP_OK);
    rd(OFS_CNT + 8'h08, 32'h0000_0000, RESP_OK);
    // Period bytes sit in lane 0, so a write without that lane is lost.
    s_axi_wstrb <= 4'hE;
    wr(OFS_PER + 8'h1C, 32'h0000_0012, RESP_OK);
    s_axi_wstrb <= 4'hF;
    rd(OFS_PER + 8'h1C, 32'h0000_00FF, RESP_OK);
    rd(OFS_DUTY, 32'h0000_0000, RESP_OK);
    rd(8'h10, 32'h0000_0000, RESP_ERR);
    wr(8'h10, 32'hFFFF_FFFF, RESP_ERR);
    // Tick every 1, 2, 2 and 4 cycles for sources A, B, SA, SB.
    wr(OFS_PRESC, 32'h0001_0110, RESP_OK);
    repeat (2) begin
      wr(OFS_CTRL, 32'h0000_0000, RESP_OK);
      ctl = $urandom & 32'h00FF_FF00 | 32'h0000_00FF;
      sel = $urandom & 32'h0000_FFFF;
      wr(OFS_CLKSEL, sel, RESP_OK);
      for (int i = 0; i < 8; i++) begin
        per[i] = 8'($urandom_range(1, 20));
        dty[i] = 8'($urandom_range(0, 22));
        wr(OFS_PER + 8'(4 * i), 32'(per[i]), RESP_OK);
        wr(OFS_DUTY + 8'(4 * i), 32'(dty[i]), RESP_OK);
      end
      rd(OFS_PER + 8'h04, 32'(per[1]), RESP_OK);
      wr(OFS_CTRL, ctl, RESP_OK);
      for (int i = 0; i < 8; i++) begin
        p = per[i];
        d = dty[i] > per[i] ? p : dty[i];
        dv = sel[2*i +: 2] == 2'd3 ? 4 : (sel[2*i +: 2] == 2'd0 ? 1 : 2);
        m = ctl[16 + i] ? (d == p ? 2 * p : (d == 0 ? 0 : 2 * d - 1))
                        : 2 * d;
        m = ctl[8 + i] ? m : 2 * p - m;
        measure(i, 8 * p * dv, 4 * m * dv);
      end
    end
    wr(OFS_CTRL, 32'h0000_0000, RESP_OK);
    wr(OFS_CLKSEL, 32'h0000_0000, RESP_OK);
    wr(OFS_PER, 32'h0000_0000, RESP_OK);
    wr(OFS_PER + 8'h04, 32'h0000_0001, RESP_OK);
    wr(OFS_DUTY, 32'h0000_0040, RESP_OK);
    wr(OFS_DUTY + 8'h04, 32'h0000_0000, RESP_OK);
    wr(OFS_CTRL, 32'h0100_0707, RESP_OK);
    measure(1, 512, 128);
    measure(0, 512, 0);
    d = dty[2] > per[2] ? per[2] : dty[2];
    measure(2, 8 * per[2], 8 * d);
    results();
  end
endmodule
bind mpt_top mpt_chk #(.NCH(NCH)) u_chk (.*);
